// >>> bench/swcfg_host.sv
`timescale 1ns/100ps
`default_nettype none
module swcfg_host #(
  parameter int BIT_CYCLES = 16
) (
  // Clock
  input wire logic clk_i,
  // Shared line, pulled up when released
  input wire logic line_i,
  output logic pull_o
);
  // Bytes heard from the device, never answered
  logic [7:0] rxq[$];
  // Byte being assembled
  logic [7:0] rx_b;

  initial pull_o = 1'b0;

  // One frame, LSB first; called just after a clock edge
  task automatic send(input logic [7:0] b);
    pull_o <= 1'b1;
    repeat (BIT_CYCLES) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      pull_o <= !b[i];
      repeat (BIT_CYCLES) @(posedge clk_i);
    end
    pull_o <= 1'b0;
    repeat (BIT_CYCLES) @(posedge clk_i);
  endtask

  // Listener samples mid-bit; own frames are skipped
  initial begin
    forever begin
      @(negedge line_i);
      if (!pull_o) begin
        repeat (BIT_CYCLES / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge clk_i);
          rx_b[i] = line_i;
        end
        rxq.push_back(rx_b);
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/swcfg_msg_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module swcfg_msg_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Open-drain line
  input wire logic single_wire_port_i,
  input wire logic single_wire_port_o,
  input wire logic single_wire_port_oe_o,
  // Events and faults
  input wire logic restart_event_i,
  input wire logic [7:0] fault0_raw_i,
  // Mode control
  input wire logic sleep_active_i,
  input wire logic low_power_req_i,
  input wire logic low_power_go_o,
  // Configuration and status
  input wire logic [7:0] setup_reg0_o,
  input wire logic [7:0] dac_ref_o,
  input wire logic [7:0] timing_o,
  input wire logic pullup_disconnect_o,
  input wire logic sleep_select_o,
  input wire logic [7:0] state_reg0_o,
  input wire logic [7:0] state_reg1_o
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Restart event seen rising
  sequence restart_rise;
    !restart_event_i ##1 restart_event_i;
  endsequence

  // All settings back at start-up values
  sequence cfg_default;
    setup_reg0_o == 8'h00 && dac_ref_o == 8'h40 && timing_o == 8'h00;
  endsequence

  a_mode_needs_req: assert property (low_power_go_o |-> $past(low_power_req_i))
    else $error("mode permission without request");
  a_mode_tx_hold: assert property ($rose(single_wire_port_oe_o) |-> ##2 !low_power_go_o)
    else $error("mode permission while sending");
  // Host start bit: well inside the start bit the permission is gone
  a_mode_rx_hold: assert property ($fell(single_wire_port_i) && !single_wire_port_oe_o
    |-> ##6 !low_power_go_o)
    else $error("mode permission while receiving");
  a_drive_low_only: assert property (!single_wire_port_o)
    else $error("open-drain data not low");
  // Each bit level holds for at least eight cycles
  a_bit_level_hold: assert property ($changed(single_wire_port_oe_o)
    |=> $stable(single_wire_port_oe_o) [*7])
    else $error("line level too short");
  a_sleep_masks_pu: assert property (sleep_active_i ##1 sleep_active_i |-> !setup_reg0_o[6])
    else $error("pull-up bit visible in sleep");
  a_sleep_forces_pu: assert property (sleep_select_o && $past(sleep_select_o)
    |-> pullup_disconnect_o)
    else $error("sleep target without disconnect");
  a_cfg_restore: assert property (restart_rise |-> ##[2:8] cfg_default)
    else $error("settings not restored on restart");
  a_flag_on_restart: assert property (restart_rise |-> ##[2:8] state_reg1_o[0])
    else $error("restart flag not set");
  // A fault0 bit held for seven cycles shows in state_reg0
  a_fault_visible: assert property ($stable(fault0_raw_i) [*7]
    |-> (state_reg0_o & fault0_raw_i) == fault0_raw_i)
    else $error("live fault missing from status");
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  // Short bit time and wait keep the run small
  localparam int BITC = 16;
  localparam int TMO = 5000;
  // Clock, reset and device pins
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic rst_evt = 1'b0;
  logic sleep = 1'b0;
  logic lp_req = 1'b0;
  logic [7:0] flt0 = 8'h00;
  logic [7:0] flt1 = 8'h00;
  // Device outputs
  logic od, oe, lp_go, pud, ssel;
  logic [7:0] setup0, dac, timing, st0, st1;
  // Wired-and line with pull-up
  logic host_pull;
  wire line;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] rb;

  assign line = !(oe | host_pull);
  always #25 clk = ~clk;

  swcfg_msg #(.TIMEOUT_CYCLES(TMO), .BIT_CYCLES(BITC)) uut (
    .clk_i(clk), .sys_rst_i(sys_rst),
    .single_wire_port_i(line), .single_wire_port_o(od),
    .single_wire_port_oe_o(oe), .chip_enable_i(ce),
    .restart_event_i(rst_evt), .fault0_raw_i(flt0),
    .fault1_raw_i(flt1), .sleep_active_i(sleep),
    .low_power_req_i(lp_req), .low_power_go_o(lp_go),
    .setup_reg0_o(setup0), .dac_ref_o(dac), .timing_o(timing),
    .pullup_disconnect_o(pud), .sleep_select_o(ssel),
    .state_reg0_o(st0), .state_reg1_o(st1)
  );

  swcfg_host #(.BIT_CYCLES(BITC)) host (
    .clk_i(clk), .line_i(line), .pull_o(host_pull)
  );

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Next device byte; unknown if none comes in time
  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    while (host.rxq.size() == 0 && n < 3 * TMO) begin
      @(posedge clk);
      n++;
    end
    if (host.rxq.size() == 0)
      b = 8'hxx;
    else
      b = host.rxq.pop_front();
  endtask

  // Host message, then the expected answer bytes
  task automatic xact(input logic [7:0] c, d, input int nd,
                      input logic [7:0] r0, input int nr,
                      input logic [7:0] r1);
    host.send(c);
    if (nd == 2) host.send(d);
    get(rb);
    chk(rb, r0);
    if (nr == 2) begin
      get(rb);
      chk(rb, r1);
    end
    repeat (2 * BITC) @(posedge clk);
  endtask

  // Defaults, single restart report, flag clear
  task automatic t_startup();
    chk(setup0, 8'h00);
    chk(dac, 8'h40);
    chk(timing, 8'h00);
    chk({7'h00, pud}, 8'h01);
    get(rb);
    chk(rb, 8'h86);
    get(rb);
    chk(rb, 8'h01);
    repeat (40 * BITC) @(posedge clk);
    chk(8'(host.rxq.size()), 8'h00);
    xact(8'h86, 8'h00, 1, 8'h46, 2, 8'h01);
    chk(st1, 8'h00);
    xact(8'h86, 8'h00, 1, 8'h46, 2, 8'h00);
  endtask

  // Setup writes, reserved bit refusal, sleep view
  task automatic t_setup();
    xact(8'h81, 8'h5f, 2, 8'h41, 1, 8'h00);
    chk(setup0, 8'h5f);
    chk({6'h00, pud, ssel}, 8'h00);
    xact(8'h82, 8'h00, 1, 8'h42, 2, 8'h5f);
    xact(8'h81, 8'hdf, 2, 8'h01, 1, 8'h00);
    chk(setup0, 8'h5f);
    xact(8'h81, 8'h73, 2, 8'h41, 1, 8'h00);
    chk({6'h00, pud, ssel}, 8'h03);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    chk(setup0, 8'h33);
    sleep <= 1'b0;
    repeat (4) @(posedge clk);
    chk(setup0, 8'h73);
  endtask

  // Rest of the command set, refusals, non-command byte
  task automatic t_codes();
    xact(8'h83, 8'h7f, 2, 8'h43, 1, 8'h00);
    chk(dac, 8'h7f);
    xact(8'h84, 8'h00, 1, 8'h44, 2, 8'h7f);
    xact(8'h87, 8'h1d, 2, 8'h47, 1, 8'h00);
    xact(8'h87, 8'he0, 2, 8'h07, 1, 8'h00);
    xact(8'h88, 8'h00, 1, 8'h48, 2, 8'h1d);
    xact(8'h89, 8'h00, 1, 8'h09, 1, 8'h00);
    xact(8'h9f, 8'h00, 1, 8'h1f, 1, 8'h00);
    xact(8'he2, 8'h00, 1, 8'h22, 1, 8'h00);
    host.send(8'h02);
    repeat (40 * BITC) @(posedge clk);
    chk(8'(host.rxq.size()), 8'h00);
  endtask

  // Lone two-byte command is refused only after the wait
  task automatic t_timeout();
    host.send(8'h81);
    repeat (TMO - 200) @(posedge clk);
    chk(8'(host.rxq.size()), 8'h00);
    get(rb);
    chk(rb, 8'h01);
    repeat (2 * BITC) @(posedge clk);
    chk(setup0, 8'h73);
  endtask

  // Rising faults report; sticky until a clear succeeds
  task automatic t_fault();
    flt0 <= 8'h04;
    get(rb);
    chk(rb, 8'h85);
    get(rb);
    chk(rb, 8'h04);
    repeat (2 * BITC) @(posedge clk);
    flt0 <= 8'h00;
    repeat (30 * BITC) @(posedge clk);
    chk(8'(host.rxq.size()), 8'h00);
    chk(st0, 8'h04);
    xact(8'h85, 8'h00, 1, 8'h45, 2, 8'h04);
    chk(st0, 8'h00);
    flt0 <= 8'h08;
    get(rb);
    chk(rb, 8'h85);
    get(rb);
    chk(rb, 8'h08);
    repeat (2 * BITC) @(posedge clk);
    xact(8'h85, 8'h00, 1, 8'h45, 2, 8'h08);
    chk(st0, 8'h08);
    flt0 <= 8'h00;
    ce <= 1'b0;
    repeat (8) @(posedge clk);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk(st0, 8'h00);
  endtask

  // Restart event restores defaults and reports once
  task automatic t_restart();
    rst_evt <= 1'b1;
    repeat (4) @(posedge clk);
    rst_evt <= 1'b0;
    repeat (8) @(posedge clk);
    chk(setup0, 8'h00);
    chk(dac, 8'h40);
    chk(timing, 8'h00);
    get(rb);
    chk(rb, 8'h86);
    get(rb);
    chk(rb, 8'h01);
    repeat (2 * BITC) @(posedge clk);
    xact(8'h86, 8'h00, 1, 8'h46, 2, 8'h01);
  endtask

  // Mode change held off by traffic; report waits its turn
  task automatic t_lowpower();
    lp_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, lp_go}, 8'h01);
    fork
      host.send(8'h82);
    join_none
    repeat (2 * BITC) @(posedge clk);
    chk({7'h00, lp_go}, 8'h00);
    get(rb);
    chk(rb, 8'h42);
    flt0 <= 8'h10;
    get(rb);
    chk(rb, 8'h00);
    get(rb);
    chk(rb, 8'h85);
    get(rb);
    chk(rb, 8'h10);
    repeat (2 * BITC) @(posedge clk);
    chk({7'h00, lp_go}, 8'h01);
    lp_req <= 1'b0;
    flt0 <= 8'h00;
    xact(8'h85, 8'h00, 1, 8'h45, 2, 8'h10);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_startup();
    t_setup();
    t_codes();
    t_timeout();
    t_fault();
    t_restart();
    t_lowpower();
    tally_and_finish();
  end
endmodule

bind swcfg_msg swcfg_msg_assertions sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .single_wire_port_i(single_wire_port_i),
  .single_wire_port_o(single_wire_port_o),
  .single_wire_port_oe_o(single_wire_port_oe_o),
  .restart_event_i(restart_event_i), .fault0_raw_i(fault0_raw_i),
  .sleep_active_i(sleep_active_i), .low_power_req_i(low_power_req_i),
  .low_power_go_o(low_power_go_o), .setup_reg0_o(setup_reg0_o),
  .dac_ref_o(dac_ref_o), .timing_o(timing_o),
  .pullup_disconnect_o(pullup_disconnect_o),
  .sleep_select_o(sleep_select_o), .state_reg0_o(state_reg0_o),
  .state_reg1_o(state_reg1_o)
);
`default_nettype wire

// >>> inc/swcfg_pkg.sv
// Behaviour
// - No low-power entry while message in flight
// - Command bytes carry bit 7 set
// - Command identity from low five bits
// - Message is command byte, optional data
// - Missing data byte: NACK after 5 ms
// - Response echoes command, bit6 ACK flag
// - Returned data follows echo immediately
// - Unsupported or erroneous command gets NACK
// - Unsolicited messages never await host reply
// - Config reads return current register contents
// - Status reads return matching status register
// - Unsolicited status only on rising bits
// - Fault clears on request or enable toggle
// - Restart sets flag, one unsolicited message
// - Flag clears on acknowledged 46H response
// - 81H writes setup_reg0, bit7 reserved zero
// - Bit 6 keeps pull-up, reads zero asleep
// - Bit 5 selects Sleep, forces disconnect
// - Bit 4 enables neutral simulator, default off
// - Bits 3,2 disable protections, default zero
// - Bits 1:0 overcurrent limit, default 00
// - Decode 81H through 88H command set
// - 81H answers 41H ACK or 01H NACK
// - Byte framing: start, eight data, stop
package swcfg_pkg;
  // Clock and line timing
  localparam int CLK_HZ = 20000000;
  localparam int CLK_KHZ = CLK_HZ / 1000;
  localparam int BAUD_HZ = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int DATA_TIMEOUT_MS = 5;
  localparam int DATA_TIMEOUT_CYCLES = DATA_TIMEOUT_MS * CLK_KHZ;
  localparam int DATA_BITS = 8;
  // Byte fields
  localparam int CMD_FLAG_BIT = 7;
  localparam int ACK_BIT = 6;
  localparam int CODE_W = 5;
  // Command codes, low five bits
  localparam logic [4:0] CODE_SET0 = 5'h01;
  localparam logic [4:0] CODE_GET0 = 5'h02;
  localparam logic [4:0] CODE_SET1 = 5'h03;
  localparam logic [4:0] CODE_GET1 = 5'h04;
  localparam logic [4:0] CODE_STATE_REG0 = 5'h05;
  localparam logic [4:0] CODE_STATE_REG1 = 5'h06;
  localparam logic [4:0] CODE_SET2 = 5'h07;
  localparam logic [4:0] CODE_GET2 = 5'h08;
  // Reserved bit masks of data bytes
  localparam logic [7:0] SET0_RSVD_MASK = 8'h80;
  localparam logic [7:0] SET2_RSVD_MASK = 8'he0;
  // setup_reg0 field positions
  localparam int S0_KEEP_PULLUP = 6;
  localparam int S0_SLEEP_SEL = 5;
  localparam int S0_NEUTRAL_EN = 4;
  localparam int S0_UVLO_DIS = 3;
  localparam int S0_SHORT_DIS = 2;
  localparam int S0_OC_LSB = 0;
  // Start-up defaults
  localparam logic [7:0] SETUP0_RESET = 8'h00;
  localparam logic [7:0] DAC_RESET = 8'h40;
  localparam logic [7:0] TIMING_RESET = 8'h00;
  // Position of restart_flag within state_reg1
  localparam int S1_RESTART_BIT = 0;
endpackage

// >>> verilog/swcfg_msg.sv
`timescale 1ns/100ps
`default_nettype none
module swcfg_msg #(
  parameter int TIMEOUT_CYCLES = swcfg_pkg::DATA_TIMEOUT_CYCLES,
  parameter int BIT_CYCLES = swcfg_pkg::BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Open-drain single_wire_port
  input wire logic single_wire_port_i,
  output logic single_wire_port_o,
  output logic single_wire_port_oe_o,
  // Device pins and analogue events
  input wire logic chip_enable_i,
  input wire logic restart_event_i,
  input wire logic [7:0] fault0_raw_i,
  input wire logic [7:0] fault1_raw_i,
  // Mode control, same clock
  input wire logic sleep_active_i,
  input wire logic low_power_req_i,
  output logic low_power_go_o,
  // Configuration outputs
  output logic [7:0] setup_reg0_o,
  output logic [7:0] dac_ref_o,
  output logic [7:0] timing_o,
  output logic pullup_disconnect_o,
  output logic sleep_select_o,
  // Status view
  output logic [7:0] state_reg0_o,
  output logic [7:0] state_reg1_o
);
  // Elaboration check: counters need room for the bit and wait times
  if (TIMEOUT_CYCLES < 2 || BIT_CYCLES < 4 || BIT_CYCLES > 2000000) begin
    $error("swcfg_msg: unsupported timing parameters");
  end

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int BW = $clog2(BIT_CYCLES * 2);
  localparam logic [TW-1:0] TO_LAST = TW'(TIMEOUT_CYCLES - 1);
  localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYCLES - 1);
  localparam logic [BW-1:0] FIRST_LAST = BW'(BIT_CYCLES + BIT_CYCLES / 2 - 1);

  typedef enum logic [1:0] {S_IDLE, S_WAIT_DATA, S_SEND} msg_state_e;

  // Synchronisers, first stage feeds only second
  logic [1:0] line_sync;
  logic [1:0] ce_sync;
  logic [1:0] rst_ev_sync;
  logic [7:0] f0_meta, f0_s;
  logic [7:0] f1_meta, f1_s;
  logic line_prev; // For falling-edge detect
  logic ce_prev; // For enable rising edge
  logic rst_ev_prev; // For restart edge

  // Receiver
  logic rx_active;
  logic [BW-1:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [7:0] rx_sh;
  logic rx_done; // One-cycle pulse per good byte

  // Transmitter
  logic tx_active;
  logic tx_go; // Pulse launching one byte
  logic [7:0] tx_byte;
  logic [9:0] tx_sh;
  logic [BW-1:0] tx_cnt;
  logic [3:0] tx_left;

  // Message control
  msg_state_e state;
  logic [7:0] cmd_q;
  logic [TW-1:0] timer;
  logic [7:0] msg_b0, msg_b1;
  logic [1:0] msg_len, msg_idx;

  // Registers
  logic [7:0] setup0, dac, timing;
  logic [7:0] sticky0, sticky1;
  logic restart_flag;
  logic [7:0] prev0, prev1;
  logic pend0, pend1; // Queued unsolicited messages

  // Decode results
  logic [4:0] code;
  logic known, two_byte;
  logic [7:0] rd_data;
  logic [7:0] state_reg0, state_reg1;
  logic [7:0] setup0_view;
  logic data_ok;
  logic ce_rise, restart_ev;
  logic cmd_in; // Command byte taken in idle
  logic take0, take1; // Unsolicited message launched
  logic rsp_load; // Solicited response loaded
  logic rsp_ack;
  logic wr_en; // Config write strobe
  logic line_free;

  // Input synchronisers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      line_sync <= 2'h3;
      ce_sync <= 2'h0;
      rst_ev_sync <= 2'h0;
      f0_meta <= 8'h00;
      f0_s <= 8'h00;
      f1_meta <= 8'h00;
      f1_s <= 8'h00;
      line_prev <= 1'b1;
      ce_prev <= 1'b0;
      rst_ev_prev <= 1'b0;
    end else begin
      line_sync <= {line_sync[0], single_wire_port_i};
      ce_sync <= {ce_sync[0], chip_enable_i};
      rst_ev_sync <= {rst_ev_sync[0], restart_event_i};
      f0_meta <= fault0_raw_i;
      f0_s <= f0_meta;
      f1_meta <= fault1_raw_i;
      f1_s <= f1_meta;
      line_prev <= line_sync[1];
      ce_prev <= ce_sync[1];
      rst_ev_prev <= rst_ev_sync[1];
    end
  end

  assign ce_rise = ce_sync[1] & ~ce_prev;
  assign restart_ev = rst_ev_sync[1] & ~rst_ev_prev;

  // Receiver: start, eight bits LSB first, stop
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_active <= 1'b0;
      rx_cnt <= '0;
      rx_idx <= 4'h0;
      rx_sh <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_active) begin
        // Own transmission echoes on the line; ignore it
        if (line_prev && !line_sync[1] && !tx_active) begin
          rx_active <= 1'b1;
          rx_cnt <= FIRST_LAST;
          rx_idx <= 4'h0;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else if (rx_idx < 4'(swcfg_pkg::DATA_BITS)) begin
        rx_sh <= {line_sync[1], rx_sh[7:1]};
        rx_idx <= rx_idx + 4'h1;
        rx_cnt <= BIT_LAST;
      end else begin
        // Stop bit low is a framing error: byte dropped
        rx_active <= 1'b0;
        rx_done <= line_sync[1];
      end
    end
  end

  // Transmitter: drive low for zero bits only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_active <= 1'b0;
      tx_sh <= 10'h3ff;
      tx_cnt <= '0;
      tx_left <= 4'h0;
      single_wire_port_o <= 1'b0;
      single_wire_port_oe_o <= 1'b0;
    end else begin
      single_wire_port_o <= 1'b0;
      if (!tx_active) begin
        single_wire_port_oe_o <= 1'b0;
        if (tx_go) begin
          tx_active <= 1'b1;
          tx_sh <= {1'b1, tx_byte, 1'b0};
          tx_cnt <= BIT_LAST;
          tx_left <= 4'h9;
          single_wire_port_oe_o <= 1'b1; // Start bit
        end
      end else if (tx_cnt != '0) begin
        tx_cnt <= tx_cnt - 1'b1;
      end else if (tx_left != 4'h0) begin
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_left <= tx_left - 4'h1;
        tx_cnt <= BIT_LAST;
        single_wire_port_oe_o <= ~tx_sh[1];
      end else begin
        tx_active <= 1'b0; // Stop bit done
        single_wire_port_oe_o <= 1'b0;
      end
    end
  end

  // Command decode and response content
  always_comb begin
    code = cmd_q[4:0];
    // Bits 6:5 set are treated as unsupported
    known = (cmd_q[6:5] == 2'h0) && (code >= swcfg_pkg::CODE_SET0)
      && (code <= swcfg_pkg::CODE_GET2);
    two_byte = (code == swcfg_pkg::CODE_SET0)
      || (code == swcfg_pkg::CODE_SET1)
      || (code == swcfg_pkg::CODE_SET2);
    setup0_view = setup0;
    if (sleep_active_i)
      setup0_view[swcfg_pkg::S0_KEEP_PULLUP] = 1'b0;
    state_reg0 = sticky0;
    state_reg1 = sticky1;
    state_reg1[swcfg_pkg::S1_RESTART_BIT] = restart_flag;
    case (code)
      swcfg_pkg::CODE_GET0: rd_data = setup0_view;
      swcfg_pkg::CODE_GET1: rd_data = dac;
      swcfg_pkg::CODE_GET2: rd_data = timing;
      swcfg_pkg::CODE_STATE_REG0: rd_data = state_reg0;
      swcfg_pkg::CODE_STATE_REG1: rd_data = state_reg1;
      default: rd_data = 8'h00;
    endcase
    // Reserved data bits set make the write an error
    case (code)
      swcfg_pkg::CODE_SET0:
        data_ok = (rx_sh & swcfg_pkg::SET0_RSVD_MASK) == 8'h00;
      swcfg_pkg::CODE_SET2:
        data_ok = (rx_sh & swcfg_pkg::SET2_RSVD_MASK) == 8'h00;
      default: data_ok = 1'b1;
    endcase
  end

  // Handshake terms between message control and registers
  always_comb begin
    cmd_in = (state == S_IDLE) && rx_done
      && rx_sh[swcfg_pkg::CMD_FLAG_BIT];
    line_free = !rx_active && !tx_active && !tx_go;
    // Unsolicited only with enable high and line free
    take0 = (state == S_IDLE) && !cmd_in && !rx_done && pend0
      && ce_sync[1] && line_free;
    take1 = (state == S_IDLE) && !cmd_in && !rx_done && !pend0 && pend1
      && ce_sync[1] && line_free;
    rsp_load = 1'b0;
    rsp_ack = 1'b0;
    wr_en = 1'b0;
    if (state == S_WAIT_DATA && rx_done) begin
      rsp_load = 1'b1;
      rsp_ack = data_ok;
      wr_en = data_ok;
    end else if (state == S_WAIT_DATA && timer == TO_LAST) begin
      rsp_load = 1'b1;
    end else if (state == S_IDLE && rx_done && rx_sh[7]) begin
      rsp_load = !(known && two_byte);
      rsp_ack = known;
    end
  end

  // Message control state machine
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
      cmd_q <= 8'h00;
      timer <= '0;
      msg_b0 <= 8'h00;
      msg_b1 <= 8'h00;
      msg_len <= 2'h0;
      msg_idx <= 2'h0;
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      tx_go <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_in) begin
            cmd_q <= rx_sh;
            timer <= '0;
            if (known_next(rx_sh)) begin
              state <= S_WAIT_DATA;
            end else begin
              // Single-byte command answered at once
              msg_b0 <= {1'b0, known_one(rx_sh), rx_sh[5:0]};
              msg_b1 <= rd_now(rx_sh);
              msg_len <= (known_one(rx_sh) && !is_write(rx_sh[4:0]))
                ? 2'h2 : 2'h1;
              msg_idx <= 2'h0;
              state <= S_SEND;
            end
          end else if (take0 || take1) begin
            // Unsolicited status, bit 7 set as a command
            msg_b0 <= {1'b1, 2'h0, take0 ? swcfg_pkg::CODE_STATE_REG0
              : swcfg_pkg::CODE_STATE_REG1};
            msg_b1 <= take0 ? state_reg0 : state_reg1;
            msg_len <= 2'h2;
            msg_idx <= 2'h0;
            state <= S_SEND;
          end
        end
        S_WAIT_DATA: begin
          timer <= timer + 1'b1;
          if (rsp_load) begin
            msg_b0 <= {1'b0, rsp_ack, cmd_q[5:0]};
            msg_len <= 2'h1;
            msg_idx <= 2'h0;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          if (!tx_active && !tx_go) begin
            if (msg_idx < msg_len) begin
              tx_go <= 1'b1;
              tx_byte <= (msg_idx == 2'h0) ? msg_b0 : msg_b1;
              msg_idx <= msg_idx + 2'h1;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Helpers evaluated on the incoming command byte
  function automatic logic is_write(input logic [4:0] c);
    is_write = (c == swcfg_pkg::CODE_SET0) || (c == swcfg_pkg::CODE_SET1)
      || (c == swcfg_pkg::CODE_SET2);
  endfunction

  function automatic logic known_one(input logic [7:0] b);
    known_one = (b[6:5] == 2'h0) && (b[4:0] >= swcfg_pkg::CODE_SET0)
      && (b[4:0] <= swcfg_pkg::CODE_GET2);
  endfunction

  function automatic logic known_next(input logic [7:0] b);
    known_next = known_one(b) && is_write(b[4:0]);
  endfunction

  // Read data for a byte not yet in cmd_q
  function automatic logic [7:0] rd_now(input logic [7:0] b);
    case (b[4:0])
      swcfg_pkg::CODE_GET0: rd_now = setup0_view;
      swcfg_pkg::CODE_GET1: rd_now = dac;
      swcfg_pkg::CODE_GET2: rd_now = timing;
      swcfg_pkg::CODE_STATE_REG0: rd_now = state_reg0;
      swcfg_pkg::CODE_STATE_REG1: rd_now = state_reg1;
      default: rd_now = 8'h00;
    endcase
  endfunction

  // Configuration registers; restart restores defaults
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || restart_ev) begin
      setup0 <= swcfg_pkg::SETUP0_RESET;
      dac <= swcfg_pkg::DAC_RESET;
      timing <= swcfg_pkg::TIMING_RESET;
    end else if (wr_en) begin
      case (cmd_q[4:0])
        swcfg_pkg::CODE_SET0: setup0 <= rx_sh;
        swcfg_pkg::CODE_SET1: dac <= rx_sh;
        swcfg_pkg::CODE_SET2: timing <= rx_sh;
        default: setup0 <= setup0;
      endcase
    end
  end

  // Sticky status; a live fault always wins over a clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sticky0 <= 8'h00;
      sticky1 <= 8'h00;
      restart_flag <= 1'b1; // Power-up counts as a restart
    end else begin
      sticky0 <= f0_s | ((cmd_in && rx_sh[4:0] == swcfg_pkg::CODE_STATE_REG0
        && known_one(rx_sh)) || ce_rise ? 8'h00 : sticky0);
      sticky1 <= f1_s | ((cmd_in && rx_sh[4:0] == swcfg_pkg::CODE_STATE_REG1
        && known_one(rx_sh)) || ce_rise ? 8'h00 : sticky1);
      if (restart_ev)
        restart_flag <= 1'b1;
      else if (cmd_in && known_one(rx_sh)
        && rx_sh[4:0] == swcfg_pkg::CODE_STATE_REG1)
        restart_flag <= 1'b0;
    end
  end

  // Rising status bits queue one unsolicited message
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev0 <= 8'h00;
      prev1 <= 8'h00; // Restart flag edge seen after reset
      pend0 <= 1'b0;
      pend1 <= 1'b0;
    end else begin
      prev0 <= state_reg0;
      prev1 <= state_reg1;
      pend0 <= (|(state_reg0 & ~prev0)) || (pend0 && !take0);
      pend1 <= (|(state_reg1 & ~prev1)) || (pend1 && !take1);
    end
  end

  // Registered outputs and low-power gate
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      low_power_go_o <= 1'b0;
      setup_reg0_o <= swcfg_pkg::SETUP0_RESET;
      dac_ref_o <= swcfg_pkg::DAC_RESET;
      timing_o <= swcfg_pkg::TIMING_RESET;
      pullup_disconnect_o <= 1'b1;
      sleep_select_o <= 1'b0;
      state_reg0_o <= 8'h00;
      state_reg1_o <= 8'h00;
    end else begin
      // Hold off mode change while any message is in flight
      low_power_go_o <= low_power_req_i && !rx_active && !tx_active
        && !tx_go && state == S_IDLE && !rx_done;
      setup_reg0_o <= setup0_view;
      dac_ref_o <= dac;
      timing_o <= timing;
      pullup_disconnect_o <= !setup0_view[swcfg_pkg::S0_KEEP_PULLUP]
        || setup0[swcfg_pkg::S0_SLEEP_SEL];
      sleep_select_o <= setup0[swcfg_pkg::S0_SLEEP_SEL];
      state_reg0_o <= state_reg0;
      state_reg1_o <= state_reg1;
    end
  end
endmodule
`default_nettype wire
